// *** verilog/port_config_device.sv ***
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module port_config_device
   import port_config_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Link to host
   cfg_link_if.device link,
   // Strap pin
   input wire logic protect_strap,
   // Transmit buffer side
   input wire logic [7:0] tx_credit_count,
   input wire logic tx_data_waiting,
   input wire logic tx_frame_complete,
   input wire logic chunk_sequence_bit,
   // Receive buffer side
   input wire logic rx_data_waiting,
   input wire logic rx_frame_complete,
   // Stamp requests
   input wire logic rx_stamp_req,
   input wire logic tx_stamp_req,
   // Mode outputs
   output logic tx_cut_through_en,
   output logic rx_cut_through_en,
   output logic frame_stamp_en,
   output logic frame_stamp_format_sel,
   output logic control_protection_en,
   // Forwarding
   output logic tx_forward_go,
   output logic rx_forward_go,
   // Stamp result
   output logic stamp_valid,
   output logic [63:0] stamp_value,
   // Interrupt
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////
   // Configuration fields

   logic [1:0] tx_credit_irq_threshold;
   logic chunk_seq_retry_en;
   logic [`IRQ_BITS-1:0] irq_status;
   logic [`IRQ_BITS-1:0] irq_enable;
   logic credit_above;
   logic [63:0] time_ns;

   ////////////////////////////////////////////////////////////////////////
   // Strap capture

   logic strap_s1;
   logic strap_s2;
   logic strap_s3;
   logic [1:0] strap_wait;
   logic strap_taken;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         strap_s1 <= 1'b0;
         strap_s2 <= 1'b0;
         strap_s3 <= 1'b0;
      end else begin
         strap_s1 <= protect_strap;
         strap_s2 <= strap_s1;
         strap_s3 <= strap_s2;
      end
   end

   // Held only until the first settled sample after reset
   wire strap_ready = (strap_wait == `STRAP_SETTLE) && (strap_s2 == strap_s3);

   always_ff @(posedge clk) begin
      if (!rstn) begin
         strap_wait <= 2'h0;
         strap_taken <= 1'b0;
         control_protection_en <= `CFG_BIT_RST;
      end else begin
         if (strap_wait != `STRAP_SETTLE) begin
            strap_wait <= strap_wait + 2'h1;
         end
         if (strap_ready && !strap_taken) begin
            strap_taken <= 1'b1;
            control_protection_en <= strap_s3;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Write integrity and decode

   wire cmp_ok = (link.wdata_n == ~link.wdata);
   wire crc_ok = (link.wcrc == crc8(link.wdata));
   wire check_ok = link.generic ? crc_ok : cmp_ok;
   wire write_ok = !control_protection_en || check_ok;
   wire prot_err_evt = link.wr && control_protection_en && !check_ok;

   wire wr_cfg = link.wr && write_ok && (link.addr == `REG_HOST_PORT_CFG);
   wire wr_ien = link.wr && write_ok && (link.addr == `REG_IRQ_ENABLE);
   wire wr_clr = link.wr && write_ok && (link.addr == `REG_IRQ_CLEAR);

   // Protection bit is loaded from the strap and bit three has no storage, so writes fall away
   always_ff @(posedge clk) begin
      if (!rstn) begin
         tx_credit_irq_threshold <= `CFG_THRESH_RST;
         tx_cut_through_en <= `CFG_BIT_RST;
         rx_cut_through_en <= `CFG_BIT_RST;
         frame_stamp_en <= `CFG_BIT_RST;
         frame_stamp_format_sel <= `CFG_BIT_RST;
         chunk_seq_retry_en <= `CFG_BIT_RST;
      end else if (wr_cfg) begin
         tx_credit_irq_threshold <=
            link.wdata[`CFG_THRESH_HI:`CFG_THRESH_LO];
         tx_cut_through_en <= link.wdata[`CFG_TX_CUT];
         rx_cut_through_en <= link.wdata[`CFG_RX_CUT];
         frame_stamp_en <= link.wdata[`CFG_STAMP_EN];
         frame_stamp_format_sel <= link.wdata[`CFG_STAMP_SEL];
         // Stored for readback only; no retry engine exists
         chunk_seq_retry_en <= link.wdata[`CFG_SEQ_EN];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path

   wire [31:0] cfg_word = {
      20'h00000,
      tx_credit_irq_threshold,
      tx_cut_through_en,
      rx_cut_through_en,
      frame_stamp_en,
      frame_stamp_format_sel,
      control_protection_en,
      chunk_seq_retry_en,
      1'b0,
      3'h0
   };

   wire [31:0] rd_mux =
      (link.addr == `REG_HOST_PORT_CFG) ? cfg_word :
      (link.addr == `REG_IRQ_STATUS) ? {29'h0, irq_status} :
      (link.addr == `REG_IRQ_ENABLE) ? {29'h0, irq_enable} :
      32'h00000000;

   wire [31:0] rd_word = link.rd ? rd_mux : 32'h00000000;
   wire prot_chunk = control_protection_en && !link.generic;
   wire prot_generic = control_protection_en && link.generic;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         link.rdata <= 32'h00000000;
         link.rdata_n <= 32'h00000000;
         link.rcrc <= 8'h00;
      end else begin
         link.rdata <= rd_word;
         link.rdata_n <= (link.rd && prot_chunk) ? ~rd_word
                                                 : 32'h00000000;
         link.rcrc <= (link.rd && prot_generic) ? crc8(rd_word)
                                                : 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Credit threshold

   wire [7:0] credit_thr =
      (tx_credit_irq_threshold == 2'h0) ? `CREDIT_THR_0 :
      (tx_credit_irq_threshold == 2'h1) ? `CREDIT_THR_1 :
      (tx_credit_irq_threshold == 2'h2) ? `CREDIT_THR_2 :
      `CREDIT_THR_3;

   // Generic protocol has no credit scheme, so the level is held low there
   wire credit_level = !link.generic && (tx_credit_count >= credit_thr);
   wire credit_evt = credit_level && !credit_above;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         credit_above <= 1'b0;
      end else begin
         credit_above <= credit_level;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Forwarding

   always_ff @(posedge clk) begin
      if (!rstn) begin
         tx_forward_go <= 1'b0;
         rx_forward_go <= 1'b0;
      end else begin
         tx_forward_go <= tx_cut_through_en ? tx_data_waiting
                                            : tx_frame_complete;
         rx_forward_go <= rx_cut_through_en ? rx_data_waiting
                                            : rx_frame_complete;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Time stamps

   wire stamp_evt = frame_stamp_en && (rx_stamp_req || tx_stamp_req);
   wire [63:0] stamp_pick = frame_stamp_format_sel ? time_ns
                                                   : {32'h0, time_ns[31:0]};

   always_ff @(posedge clk) begin
      if (!rstn) begin
         time_ns <= 64'h0;
         stamp_valid <= 1'b0;
         stamp_value <= 64'h0;
      end else begin
         time_ns <= time_ns + `CLK_PERIOD_NS;
         stamp_valid <= stamp_evt;
         if (stamp_evt) begin
            stamp_value <= stamp_pick;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupts

   wire [`IRQ_BITS-1:0] irq_events = {stamp_evt, prot_err_evt, credit_evt};
   wire [`IRQ_BITS-1:0] clr_mask = wr_clr ? link.wdata[`IRQ_BITS-1:0]
                                          : {`IRQ_BITS{1'b0}};
   // Set beats clear so an event in the clearing cycle survives
   wire [`IRQ_BITS-1:0] next_status = (irq_status & ~clr_mask) | irq_events;
   wire [`IRQ_BITS-1:0] next_enable = wr_ien ? link.wdata[`IRQ_BITS-1:0]
                                             : irq_enable;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         irq_status <= {`IRQ_BITS{1'b0}};
         irq_enable <= {`IRQ_BITS{1'b0}};
         irq <= 1'b0;
      end else begin
         irq_status <= next_status;
         irq_enable <= next_enable;
         irq <= |(next_status & next_enable);
      end
   end

endmodule // port_config_device

`default_nettype wire

// *** verilog/port_config_consts.svh ***
`ifndef PORT_CONFIG_CONSTS_SVH
`define PORT_CONFIG_CONSTS_SVH

// Register indices on the link (byte address is four times the index)
`define REG_HOST_PORT_CFG 8'h04
`define REG_IRQ_STATUS 8'h10
`define REG_IRQ_ENABLE 8'h11
`define REG_IRQ_CLEAR 8'h12

// Field positions in host_port_configuration
`define CFG_THRESH_HI 11
`define CFG_THRESH_LO 10
`define CFG_TX_CUT 9
`define CFG_RX_CUT 8
`define CFG_STAMP_EN 7
`define CFG_STAMP_SEL 6
`define CFG_PROTECT 5
`define CFG_SEQ_EN 4
`define CFG_RESERVED3 3

// Field reset values
`define CFG_THRESH_RST 2'h0
`define CFG_BIT_RST 1'h0

// Credit thresholds per threshold code
`define CREDIT_THR_0 8'h01
`define CREDIT_THR_1 8'h04
`define CREDIT_THR_2 8'h08
`define CREDIT_THR_3 8'h10

// Interrupt status bits
`define IRQ_CREDIT 0
`define IRQ_PROT_ERR 1
`define IRQ_STAMP 2
`define IRQ_BITS 3

// Integrity check polynomial
`define CRC8_POLY 8'h07

// Time base
`define CLK_PERIOD_NS 64'h000000000000000a

// Strap sampling
`define STRAP_SETTLE 2'h3

// Host register indices on the software port
`define HREG_CTRL 4'h0
`define HREG_ADDR 4'h1
`define HREG_WDATA 4'h2
`define HREG_CMD 4'h3
`define HREG_STATUS 4'h4
`define HREG_RDATA 4'h5

// Host field positions
`define HCTL_GENERIC 0
`define HCTL_EXPECT_PROT 1
`define HCMD_WRITE 0
`define HCMD_READ 1
`define HST_BUSY 0
`define HST_DONE 1
`define HST_REFUSED 2
`define HST_INTEGRITY 3
`define HST_SEALED 4

`endif

// *** verilog/port_config_pkg.sv ***
`include "port_config_consts.svh"

package port_config_pkg;

   typedef enum logic [1:0] {
      host_idle,
      host_issue,
      host_capture
   } host_state_t;

   typedef logic [7:0] crc8_t;

   function automatic crc8_t crc8(input logic [31:0] d);
      crc8_t c;
      c = 8'h00;
      for (int i = 31; i >= 0; i--) begin
         if (c[7] ^ d[i]) begin
            c = {c[6:0], 1'b0} ^ `CRC8_POLY;
         end else begin
            c = {c[6:0], 1'b0};
         end
      end
      return c;
   endfunction

endpackage

// *** verilog/cfg_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface cfg_link_if;
   // Request from host
   logic wr;
   logic rd;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic [31:0] wdata_n;
   logic [7:0] wcrc;
   logic generic;
   // Answer from device, cycle after rd
   logic [31:0] rdata;
   logic [31:0] rdata_n;
   logic [7:0] rcrc;

   modport device (
      input wr, rd, addr, wdata, wdata_n, wcrc, generic,
      output rdata, rdata_n, rcrc
   );

   modport host (
      output wr, rd, addr, wdata, wdata_n, wcrc, generic,
      input rdata, rdata_n, rcrc
   );
endinterface

`default_nettype wire

// *** verilog/port_config_host.sv ***
`timescale 1ns/1ps
`default_nettype none

module port_config_host
   import port_config_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Software port
   input wire logic [3:0] sw_addr,
   input wire logic [31:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   output logic [31:0] sw_rdata,
   // Link to device
   cfg_link_if.host link
);

   ////////////////////////////////////////////////////////////////////////
   // Software registers

   host_state_t state;
   logic generic_mode;
   logic expect_prot;
   logic [7:0] tgt_addr;
   logic [31:0] tgt_wdata;
   logic [31:0] rd_result;
   logic done;
   logic refused;
   logic integrity_err;
   logic sealed;
   logic rx_cut_shadow;

   wire busy = (state != host_idle);
   wire go_wr = sw_wr && (sw_addr == `HREG_CMD) && sw_wdata[`HCMD_WRITE]
                && !busy;
   wire go_rd = sw_wr && (sw_addr == `HREG_CMD) && sw_wdata[`HCMD_READ]
                && !sw_wdata[`HCMD_WRITE] && !busy;
   wire to_cfg = (tgt_addr == `REG_HOST_PORT_CFG);

   // Generic protocol forces Rx cut-through off in every config write
   wire [31:0] out_data = (to_cfg && generic_mode)
      ? (tgt_wdata & ~(32'h1 << `CFG_RX_CUT)) : tgt_wdata;
   // Once forwarding setup began, Rx cut-through may not change
   wire refuse_wr = to_cfg && sealed
      && (out_data[`CFG_RX_CUT] != rx_cut_shadow);

   wire [31:0] status_word = {27'h0, sealed, integrity_err, refused, done,
                              busy};
   wire [31:0] sw_mux =
      (sw_addr == `HREG_CTRL) ? {30'h0, expect_prot, generic_mode} :
      (sw_addr == `HREG_ADDR) ? {24'h0, tgt_addr} :
      (sw_addr == `HREG_WDATA) ? tgt_wdata :
      (sw_addr == `HREG_STATUS) ? status_word :
      (sw_addr == `HREG_RDATA) ? rd_result :
      32'h00000000;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         sw_rdata <= 32'h00000000;
         generic_mode <= 1'b0;
         expect_prot <= 1'b0;
         tgt_addr <= 8'h00;
         tgt_wdata <= 32'h00000000;
      end else begin
         sw_rdata <= sw_rd ? sw_mux : 32'h00000000;
         if (sw_wr && (sw_addr == `HREG_CTRL)) begin
            generic_mode <= sw_wdata[`HCTL_GENERIC];
            expect_prot <= sw_wdata[`HCTL_EXPECT_PROT];
         end
         if (sw_wr && (sw_addr == `HREG_ADDR) && !busy) begin
            tgt_addr <= sw_wdata[7:0];
         end
         if (sw_wr && (sw_addr == `HREG_WDATA) && !busy) begin
            tgt_wdata <= sw_wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Link sequencer

   // Both checks are sent always; the device looks only at the active one
   wire check_bad = generic_mode
      ? (link.rcrc != crc8(link.rdata))
      : (link.rdata_n != ~link.rdata);

   always_ff @(posedge clk) begin
      if (!rstn) begin
         state <= host_idle;
         link.wr <= 1'b0;
         link.rd <= 1'b0;
         link.addr <= 8'h00;
         link.wdata <= 32'h00000000;
         link.wdata_n <= 32'h00000000;
         link.wcrc <= 8'h00;
         link.generic <= 1'b0;
         rd_result <= 32'h00000000;
         done <= 1'b0;
         refused <= 1'b0;
         integrity_err <= 1'b0;
         sealed <= 1'b0;
         rx_cut_shadow <= 1'b0;
      end else begin
         link.wr <= 1'b0;
         link.rd <= 1'b0;
         link.generic <= generic_mode;
         unique case (state)
            host_idle: begin
               if (go_wr && refuse_wr) begin
                  refused <= 1'b1;
                  done <= 1'b1;
               end else if (go_wr) begin
                  link.wr <= 1'b1;
                  link.addr <= tgt_addr;
                  link.wdata <= out_data;
                  link.wdata_n <= ~out_data;
                  link.wcrc <= crc8(out_data);
                  done <= 1'b0;
                  refused <= 1'b0;
                  if (to_cfg) begin
                     rx_cut_shadow <= out_data[`CFG_RX_CUT];
                  end else begin
                     sealed <= 1'b1;
                  end
                  state <= host_issue;
               end else if (go_rd) begin
                  link.rd <= 1'b1;
                  link.addr <= tgt_addr;
                  done <= 1'b0;
                  refused <= 1'b0;
                  integrity_err <= 1'b0;
                  state <= host_capture;
               end
            end
            host_issue: begin
               done <= 1'b1;
               state <= host_idle;
            end
            host_capture: begin
               // Device answer stands in this cycle only
               if (!link.rd) begin
                  rd_result <= link.rdata;
                  integrity_err <= expect_prot && check_bad;
                  done <= 1'b1;
                  state <= host_idle;
               end
            end
         endcase
      end
   end

endmodule // port_config_host

`default_nettype wire

// *** tb/port_config_props.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "port_config_consts.svh"

module port_config_props (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Link request
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic [31:0] wdata_n,
   input wire logic [7:0] wcrc,
   input wire logic generic,
   // Link answer
   input wire logic [31:0] rdata,
   input wire logic [31:0] rdata_n,
   input wire logic [7:0] rcrc,
   // Device mode
   input wire logic control_protection_en
);
   // Own reference, kept apart from the design's function
   function automatic logic [7:0] crc_ref(input logic [31:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 31; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
      end
      return c;
   endfunction

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   ////////////////////////////////////////////////////////////////////////////
   property p_wr_pair;
      wr |-> wdata_n == ~wdata && !rd;
   endproperty
   a_wr_pair: assert property (p_wr_pair)
      else $error("write complement wrong");
   property p_wr_crc;
      wr |-> wcrc == crc_ref(wdata);
   endproperty
   a_wr_crc: assert property (p_wr_crc)
      else $error("write crc wrong");
   property p_gen_rx;
      wr && generic && addr == `REG_HOST_PORT_CFG |-> !wdata[`CFG_RX_CUT];
   endproperty
   a_gen_rx: assert property (p_gen_rx)
      else $error("rx cut-through set in generic mode");
   property p_rd_comp;
      rd && !generic && control_protection_en |=> rdata_n == ~rdata;
   endproperty
   a_rd_comp: assert property (p_rd_comp)
      else $error("read complement wrong");
   property p_rd_crc;
      rd && generic && control_protection_en |=> rcrc == crc_ref(rdata);
   endproperty
   a_rd_crc: assert property (p_rd_crc)
      else $error("read crc wrong");
   property p_rd_plain;
      rd && !control_protection_en |=> rdata_n == 32'h0 && rcrc == 8'h00;
   endproperty
   a_rd_plain: assert property (p_rd_plain)
      else $error("check word without protection");
   // Answer stands only in the cycle after a read
   property p_idle;
      !rd |=> rdata == 32'h0 && rdata_n == 32'h0 && rcrc == 8'h00;
   endproperty
   a_idle: assert property (p_idle)
      else $error("answer outside read slot");
   property p_cfg_fields;
      rd && addr == `REG_HOST_PORT_CFG |=>
         rdata[31:12] == 20'h0 && rdata[3:0] == 4'h0;
   endproperty
   a_cfg_fields: assert property (p_cfg_fields)
      else $error("reserved config bits not zero");
   property p_prot_ro;
      rd && addr == `REG_HOST_PORT_CFG |=>
         rdata[`CFG_PROTECT] == $past(control_protection_en);
   endproperty
   a_prot_ro: assert property (p_prot_ro)
      else $error("protection bit differs from strap");

   c_cfg_write: cover property (wr && addr == `REG_HOST_PORT_CFG);
   c_rd_comp: cover property (rd && !generic && control_protection_en);
   c_rd_crc: cover property (rd && generic && control_protection_en);
endmodule // port_config_props

`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "port_config_consts.svh"
`define CHK(nm, exp, got) begin \
   tests_run++; \
   if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("Error %s expected %h seen %h", nm, exp, got); \
   end \
end

module testbench;
   import port_config_pkg::*;
   logic clk, rstn, protect_strap, chunk_sequence_bit;
   logic [7:0] tx_credit_count;
   logic tx_data_waiting, tx_frame_complete;
   logic rx_data_waiting, rx_frame_complete;
   logic rx_stamp_req, tx_stamp_req, tx_cut_through_en, rx_cut_through_en;
   logic frame_stamp_en, frame_stamp_format_sel, control_protection_en;
   logic tx_forward_go, rx_forward_go, stamp_valid, irq, sw_wr, sw_rd;
   logic [63:0] stamp_value, s1, s2;
   logic [3:0] sw_addr;
   logic [31:0] sw_wdata, sw_rdata, d;
   logic v;
   int n_mismatch = 0, tests_run = 0, cycles = 0;
   logic [7:0] thr [4] = '{8'h01, 8'h04, 8'h08, 8'h10};

   cfg_link_if link();
   port_config_device port_config_device_i (.clk, .rstn, .link(link),
      .protect_strap, .tx_credit_count, .tx_data_waiting, .tx_frame_complete,
      .chunk_sequence_bit, .rx_data_waiting, .rx_frame_complete, .rx_stamp_req,
      .tx_stamp_req, .tx_cut_through_en, .rx_cut_through_en, .frame_stamp_en,
      .frame_stamp_format_sel, .control_protection_en, .tx_forward_go,
      .rx_forward_go, .stamp_valid, .stamp_value, .irq);
   port_config_host port_config_host_i (.clk, .rstn, .sw_addr, .sw_wdata,
      .sw_wr, .sw_rd, .sw_rdata, .link(link));
   port_config_props port_config_props_i (.clk, .rstn, .wr(link.wr),
      .rd(link.rd), .addr(link.addr), .wdata(link.wdata),
      .wdata_n(link.wdata_n), .wcrc(link.wcrc), .generic(link.generic),
      .rdata(link.rdata), .rdata_n(link.rdata_n), .rcrc(link.rcrc),
      .control_protection_en);

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Sequence bit keeps moving; the device must not care
   always @(posedge clk) begin
      cycles <= cycles + 1;
      chunk_sequence_bit <= cycles[2];
      if (cycles == 20000) begin
         n_mismatch++;
         summarize();
      end
   end

   task automatic summarize;
      $display("Checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic sw_write(input logic [3:0] a, input logic [31:0] wd);
      @(posedge clk);
      sw_addr <= a;
      sw_wdata <= wd;
      sw_wr <= 1'b1;
      @(posedge clk);
      sw_wr <= 1'b0;
   endtask

   task automatic sw_read(input logic [3:0] a, output logic [31:0] rd);
      @(posedge clk);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge clk);
      sw_rd <= 1'b0;
      #1;
      rd = sw_rdata;
   endtask

   // Bounded poll on busy; a stuck host counts as a mismatch
   task automatic dev_cmd(input logic [1:0] cmd, input logic [7:0] idx,
                          input logic [31:0] wd);
      logic [31:0] st;
      sw_write(`HREG_ADDR, {24'h0, idx});
      sw_write(`HREG_WDATA, wd);
      sw_write(`HREG_CMD, {30'h0, cmd});
      st = 32'h1;
      for (int i = 0; i < 20 && st[`HST_BUSY] !== 1'b0; i++) begin
         sw_read(`HREG_STATUS, st);
      end
      `CHK("host idle", 1'b0, st[`HST_BUSY])
   endtask

   task automatic dev_rd(input logic [7:0] idx, output logic [31:0] rd);
      dev_cmd(2'b10, idx, 32'h0);
      sw_read(`HREG_RDATA, rd);
   endtask

   task automatic do_reset(input logic strap);
      @(posedge clk);
      rstn <= 1'b0;
      protect_strap <= strap;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      repeat (8) @(posedge clk);
   endtask

   task automatic stamp(input logic from_rx, output logic sv,
                        output logic [63:0] val);
      @(posedge clk);
      rx_stamp_req <= from_rx;
      tx_stamp_req <= !from_rx;
      @(posedge clk);
      rx_stamp_req <= 1'b0;
      tx_stamp_req <= 1'b0;
      #1;
      sv = stamp_valid;
      val = stamp_value;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {rstn, protect_strap, tx_data_waiting} = 3'h0;
      {tx_frame_complete, rx_data_waiting, rx_frame_complete} = 3'h0;
      {rx_stamp_req, tx_stamp_req, sw_wr, sw_rd} = 4'h0;
      tx_credit_count = 8'h00;
      sw_addr = 4'h0;
      sw_wdata = 32'h0;
      do_reset(1'b0);
      sw_write(`HREG_CTRL, 32'h0);
      dev_cmd(2'b01, `REG_HOST_PORT_CFG, 32'hffffffff);
      dev_rd(`REG_HOST_PORT_CFG, d);
      `CHK("config readback", 32'h00000fd0, d)
      d = {27'h0, tx_cut_through_en, rx_cut_through_en, frame_stamp_en,
         frame_stamp_format_sel, control_protection_en};
      `CHK("mode outputs", 32'h0000001e, d)
      dev_rd(8'h20, d);
      `CHK("unmapped read", 32'h0, d)
      // Cut-through forwards on partial data, store-and-forward waits
      @(posedge clk);
      tx_data_waiting <= 1'b1;
      rx_data_waiting <= 1'b1;
      repeat (3) @(posedge clk);
      #1 `CHK("forward cut", 2'b11, {tx_forward_go, rx_forward_go})
      dev_cmd(2'b01, `REG_HOST_PORT_CFG, 32'h0);
      repeat (2) @(posedge clk);
      #1 `CHK("fwd store", 2'b00, {tx_forward_go, rx_forward_go})
      @(posedge clk);
      tx_frame_complete <= 1'b1;
      rx_frame_complete <= 1'b1;
      repeat (3) @(posedge clk);
      #1 `CHK("fwd whole", 2'b11, {tx_forward_go, rx_forward_go})
      // Stamps: five cycles apart is 50 ns on the time base
      dev_cmd(2'b01, `REG_HOST_PORT_CFG, 32'h0c0);
      stamp(1'b0, v, s1);
      `CHK("stamp tx valid", 1'b1, v)
      repeat (3) @(posedge clk);
      stamp(1'b1, v, s2);
      `CHK("stamp interval", 64'h0000000000000032, s2 - s1)
      dev_cmd(2'b01, `REG_HOST_PORT_CFG, 32'h080);
      stamp(1'b1, v, s1);
      `CHK("stamp 32 bit", 33'h100000000, {v, s1[63:32]})
      dev_cmd(2'b01, `REG_HOST_PORT_CFG, 32'h040);
      stamp(1'b0, v, s1);
      `CHK("stamp off", 1'b0, v)
      dev_rd(`REG_IRQ_STATUS, d);
      `CHK("stamp status", 1'b1, d[`IRQ_STAMP])
      // Credit threshold codes, interrupt raised and cleared
      dev_cmd(2'b01, `REG_IRQ_ENABLE, 32'h1);
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         tx_credit_count <= thr[k] - 8'h01;
         dev_cmd(2'b01, `REG_HOST_PORT_CFG, {20'h0, k[1:0], 10'h0});
         dev_cmd(2'b01, `REG_IRQ_CLEAR, 32'h7);
         #1 `CHK("irq below", 1'b0, irq)
         @(posedge clk);
         tx_credit_count <= thr[k];
         repeat (4) @(posedge clk);
         #1 `CHK("irq at threshold", 1'b1, irq)
         dev_rd(`REG_IRQ_STATUS, d);
         `CHK("credit status", 1'b1, d[`IRQ_CREDIT])
         dev_cmd(2'b01, `REG_IRQ_CLEAR, 32'h1);
         #1 `CHK("irq cleared", 1'b0, irq)
      end
      // Masked event still sets status
      dev_cmd(2'b01, `REG_IRQ_ENABLE, 32'h0);
      @(posedge clk);
      tx_credit_count <= 8'h00;
      repeat (2) @(posedge clk);
      tx_credit_count <= 8'h10;
      repeat (4) @(posedge clk);
      #1 `CHK("irq masked", 1'b0, irq)
      dev_rd(`REG_IRQ_STATUS, d);
      `CHK("masked status", 1'b1, d[`IRQ_CREDIT])
      // Strap high; later pin changes are not seen
      do_reset(1'b1);
      protect_strap <= 1'b0;
      repeat (4) @(posedge clk);
      #1 `CHK("strap captured", 1'b1, control_protection_en)
      sw_write(`HREG_CTRL, 32'h2);
      dev_cmd(2'b01, `REG_HOST_PORT_CFG, 32'h100);
      dev_rd(`REG_HOST_PORT_CFG, d);
      `CHK("protected readback", 32'h120, d)
      sw_read(`HREG_STATUS, d);
      `CHK("chunk integrity", 1'b0, d[`HST_INTEGRITY])
      sw_write(`HREG_CTRL, 32'h3);
      dev_cmd(2'b01, `REG_HOST_PORT_CFG, 32'h1c0);
      dev_rd(`REG_HOST_PORT_CFG, d);
      `CHK("generic readback", 32'h0e0, d)
      `CHK("generic rx cut", 1'b0, rx_cut_through_en)
      sw_read(`HREG_STATUS, d);
      `CHK("generic integrity", 1'b0, d[`HST_INTEGRITY])
      // Late change of rx cut-through after setup is held back
      dev_cmd(2'b01, `REG_IRQ_ENABLE, 32'h0);
      sw_write(`HREG_CTRL, 32'h2);
      dev_cmd(2'b01, `REG_HOST_PORT_CFG, 32'h100);
      sw_read(`HREG_STATUS, d);
      `CHK("late rx cut refused", 1'b1, d[`HST_REFUSED])
      `CHK("rx cut unchanged", 1'b0, rx_cut_through_en)
      summarize();
   end
endmodule // testbench

`default_nettype wire
